// >>> src/nms_pkg.sv
/*
 * Constants, field layouts and types for the NCO group sync block.
 * Assumes an 8-bit register port with 12-bit byte addresses.
 */
package nms_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] NMS_OFS_PERIOD_LO = 12'h0C7;
    localparam logic [11:0] NMS_OFS_PERIOD_HI = 12'h0C8;
    localparam logic [11:0] NMS_OFS_SYSREF_MODE = 12'h0CB;
    localparam logic [11:0] NMS_OFS_GROUP_CTRL = 12'h0CC;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int NMS_POS_EXTRA = 4;
    localparam int NMS_POS_TRIG = 2;
    localparam int NMS_POS_ROLE = 0;
    localparam int NMS_POS_PERIOD_EN = 4;
    localparam int NMS_POS_RX_MODE = 2;
    localparam int NMS_POS_TX_MODE = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0] NMS_RST_EXTRA = 4'h0;
    localparam logic [1:0] NMS_RST_TRIG = 2'h1;
    localparam logic [1:0] NMS_RST_ROLE = 2'h0;
    localparam logic [1:0] NMS_RST_RX_MODE = 2'h1;
    localparam logic [1:0] NMS_RST_TX_MODE = 2'h1;
    localparam logic [3:0] NMS_RST_SYSREF_RSVD = 4'h1;
    localparam logic [10:0] NMS_RST_PERIOD = 11'h180;
    localparam logic NMS_RST_PERIOD_EN = 1'b0;

    // ****************************************
    // Encodings
    // ****************************************
    localparam logic [1:0] NMS_ROLE_MASTER = 2'h1;
    localparam logic [1:0] NMS_ROLE_SLAVE = 2'h2;
    localparam logic [1:0] NMS_SRC_SYSREF = 2'h0;
    localparam logic [1:0] NMS_SRC_LMFC_RISE = 2'h1;
    localparam logic [1:0] NMS_SRC_LMFC_FALL = 2'h2;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [3:0] extra_multiframe_delay_count;
        logic [1:0] group_sync_trigger_select;
        logic [1:0] group_sync_role;
    } nms_ctrl_t;

    typedef struct packed {
        logic [1:0] rx_mode;
        logic [1:0] tx_oscillator_sysref_align_mode;
    } nms_sref_t;

    typedef enum logic [1:0] {
        NMS_IDLE = 2'b01,
        NMS_WAIT = 2'b10
    } nms_state_t;
endpackage : nms_pkg

// >>> src/nms_edge_sync.sv
/*
 * Two-flop synchroniser with rising-edge pulse output.
 * Assumes an asynchronous level input and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module nms_edge_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Level in, pulse out
    input wire logic async_i,
    output logic rise_o
);
    logic meta;
    logic sync;
    logic last;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            meta <= async_i;
            sync <= meta;
            last <= sync;
            rise_o <= sync & ~last;
        end
    end
endmodule : nms_edge_sync
`default_nettype wire

// >>> src/nms_group_sync.sv
/*
 * NCO group sync control: roles, trigger choice, extra multiframe delay,
 * SYSREF-aligned reset mode and local multiframe clock generation.
 * Assumes the clock runs at the converter rate divided by four and that
 * sysref_i and group_sync_in_i come from pins.
 */
// Behaviour
// - A master adds a 4-bit count, reset 0, of extra multiframes.
// - Only a master on a multiframe edge trigger uses the extra count.
// - Master trigger is SYSREF 00, rise 01 or fall 10, resetting to 01.
// - Role: off 00 or 11, master 01, slave 10; resets to off.
// - Neither master nor slave: SYSREF resets at once 00, next rise 01, next fall 10.
// - The multiframe period may come from an 11-bit software value.
`timescale 1ns/10ps
`default_nettype none
module nms_group_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Timing inputs
    input wire logic sysref_i,
    input wire logic [10:0] link_multiframe_period_i,
    // Group sync link
    input wire logic group_sync_in_i,
    output logic group_sync_out_o,
    // Outputs to datapath
    output logic multiframe_clk_o,
    output logic nco_reset_o
);
    import nms_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    nms_ctrl_t nco_group_sync_control;
    nms_sref_t sref_mode;
    logic [10:0] software_multiframe_period;
    logic period_sel_sw;

    wire at_lo = (reg_addr_i == NMS_OFS_PERIOD_LO);
    wire at_hi = (reg_addr_i == NMS_OFS_PERIOD_HI);
    wire at_sr = (reg_addr_i == NMS_OFS_SYSREF_MODE);
    wire at_ctl = (reg_addr_i == NMS_OFS_GROUP_CTRL);
    wire wr_lo = reg_wr_i && at_lo;
    wire wr_hi = reg_wr_i && at_hi;
    wire wr_sr = reg_wr_i && at_sr;
    wire wr_ctl = reg_wr_i && at_ctl;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            nco_group_sync_control <= {NMS_RST_EXTRA, NMS_RST_TRIG,
                                       NMS_RST_ROLE};
            sref_mode <= {NMS_RST_RX_MODE, NMS_RST_TX_MODE};
            software_multiframe_period <= NMS_RST_PERIOD;
            period_sel_sw <= NMS_RST_PERIOD_EN;
        end else begin
            if (wr_ctl) begin
                nco_group_sync_control <= reg_wdata_i;
            end
            if (wr_sr) begin
                sref_mode <= reg_wdata_i[3:0];
            end
            if (wr_lo) begin
                software_multiframe_period[7:0] <= reg_wdata_i;
            end
            if (wr_hi) begin
                software_multiframe_period[10:8] <= reg_wdata_i[2:0];
                period_sel_sw <= reg_wdata_i[NMS_POS_PERIOD_EN];
            end
        end
    end

    wire [7:0] rd_hi = {3'h0, period_sel_sw, 1'b0,
                        software_multiframe_period[10:8]};
    wire [7:0] rd_sr = {NMS_RST_SYSREF_RSVD, sref_mode};
    wire [7:0] next_rdata =
        at_lo ? software_multiframe_period[7:0] :
        at_hi ? rd_hi :
        at_sr ? rd_sr :
        at_ctl ? nco_group_sync_control :
        8'h00;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic sysref_rise;
    logic sync_in_rise;

    nms_edge_sync u_sysref_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(sysref_i),
        .rise_o(sysref_rise)
    );

    nms_edge_sync u_group_in_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(group_sync_in_i),
        .rise_o(sync_in_rise)
    );

    // ****************************************
    // Multiframe clock
    // ****************************************
    logic [10:0] mf_count;
    logic mf_rise;
    logic mf_fall;

    wire [10:0] mf_period = period_sel_sw
        ? software_multiframe_period
        : link_multiframe_period_i;
    wire [10:0] mf_up = mf_count + 11'h001;
    wire mf_wrap = mf_up >= mf_period;
    wire [10:0] next_mf_count = mf_wrap ? 11'h000 : mf_up;
    wire [10:0] mf_half = mf_period >> 1;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mf_count <= 11'h000;
            mf_rise <= 1'b0;
            mf_fall <= 1'b0;
            multiframe_clk_o <= 1'b0;
        end else begin
            mf_count <= next_mf_count;
            mf_rise <= (next_mf_count == 11'h000);
            mf_fall <= (next_mf_count == mf_half);
            multiframe_clk_o <= (next_mf_count < mf_half);
        end
    end

    // ****************************************
    // Trigger selection
    // ****************************************
    wire [1:0] role = nco_group_sync_control.group_sync_role;
    wire is_master = (role == NMS_ROLE_MASTER);
    wire is_slave = (role == NMS_ROLE_SLAVE);
    wire [1:0] edge_code = is_master
        ? nco_group_sync_control.group_sync_trigger_select
        : sref_mode.tx_oscillator_sysref_align_mode;
    wire fire_now = (edge_code == NMS_SRC_SYSREF);
    wire edge_valid = fire_now || (edge_code == NMS_SRC_LMFC_RISE)
                      || (edge_code == NMS_SRC_LMFC_FALL);
    wire sel_edge = (edge_code == NMS_SRC_LMFC_RISE) ? mf_rise
                    : mf_fall;
    wire [3:0] extra_load = (is_master && !fire_now)
        ? nco_group_sync_control.extra_multiframe_delay_count
        : 4'h0;

    // ****************************************
    // Reset sequencer
    // ****************************************
    nms_state_t state;
    nms_state_t next_state;
    logic [3:0] remain;
    logic [3:0] next_remain;
    logic fire;

    always_comb begin
        next_state = state;
        next_remain = remain;
        fire = 1'b0;
        unique case (state)
            NMS_IDLE: begin
                if (is_slave) begin
                    fire = sync_in_rise;
                end else if (sysref_rise && edge_valid) begin
                    if (fire_now) begin
                        fire = 1'b1;
                    end else begin
                        next_state = NMS_WAIT;
                        next_remain = extra_load;
                    end
                end
            end
            NMS_WAIT: begin
                if (is_slave || !edge_valid || fire_now) begin
                    next_state = NMS_IDLE;
                end else if (sel_edge) begin
                    if (remain == 4'h0) begin
                        fire = 1'b1;
                        next_state = NMS_IDLE;
                    end else begin
                        next_remain = remain - 4'h1;
                    end
                end
            end
            default: begin
                next_state = NMS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= NMS_IDLE;
            remain <= 4'h0;
            nco_reset_o <= 1'b0;
            group_sync_out_o <= 1'b0;
        end else begin
            state <= next_state;
            remain <= next_remain;
            nco_reset_o <= fire;
            group_sync_out_o <= fire && is_master;
        end
    end
endmodule : nms_group_sync
`default_nettype wire

// >>> test/nms_chk.sv
/*
 * Port checker for the NCO group sync block.
 * Assumes binding into every instance of nms_group_sync.
 */
`timescale 1ns/10ps
`default_nettype none
module nms_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // Sync outputs
    input wire logic group_sync_out_o,
    input wire logic multiframe_clk_o,
    input wire logic nco_reset_o
);
    import nms_pkg::*;

    wire logic mapped = reg_addr_i inside {NMS_OFS_PERIOD_LO,
        NMS_OFS_PERIOD_HI, NMS_OFS_SYSREF_MODE, NMS_OFS_GROUP_CTRL};
    wire logic ctrl_sel = reg_addr_i == NMS_OFS_GROUP_CTRL;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_nco_pulse: assert property (nco_reset_o |=> !nco_reset_o)
        else $error("nco reset longer than one cycle");
    a_out_pulse: assert property (
        group_sync_out_o |=> !group_sync_out_o)
        else $error("group sync out longer than one cycle");
    a_out_pairs: assert property (group_sync_out_o |-> nco_reset_o)
        else $error("group sync out without nco reset");
    a_rdata_holds: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_ctrl_readback: assert property (
        reg_wr_i && ctrl_sel ##1 reg_rd_i && !reg_wr_i && ctrl_sel
        |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("control register readback wrong");
    a_unmapped_zero: assert property (
        reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_sref_fixed: assert property (
        reg_rd_i && reg_addr_i == NMS_OFS_SYSREF_MODE
        |=> reg_rdata_o[7:4] == NMS_RST_SYSREF_RSVD)
        else $error("sysref mode upper bits wrong");
    a_period_rsvd: assert property (
        reg_rd_i && reg_addr_i == NMS_OFS_PERIOD_HI
        |=> reg_rdata_o[7:5] == 3'h0 && !reg_rdata_o[3])
        else $error("period high reserved bits set");
    a_rst_quiet: assert property (disable iff (1'b0)
        sys_rst_i |=> !nco_reset_o && !group_sync_out_o && !multiframe_clk_o)
        else $error("outputs active after reset");
    c_master: cover property (nco_reset_o && group_sync_out_o);
    c_local: cover property (nco_reset_o && !group_sync_out_o);
    c_frame: cover property ($rose(multiframe_clk_o));
endmodule : nms_chk
bind nms_group_sync nms_chk chk_u (.clk_i, .sys_rst_i, .reg_addr_i,
    .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .group_sync_out_o,
    .multiframe_clk_o, .nco_reset_o);
`default_nettype wire

// >>> test/nms_far_master.sv
/*
 * Far master of the sync group: sends the sync indication.
 * Assumes send_i is a one-cycle request set on the falling edge.
 */
`timescale 1ns/10ps
`default_nettype none
module nms_far_master (
    // Clock and request
    input wire logic clk_i,
    input wire logic send_i,
    // Sync line to the slave
    output logic sync_o
);
    int hold = 0;
    always @(posedge clk_i) begin
        if (send_i) hold <= 4;
        else if (hold > 0) hold <= hold - 1;
    end
    assign sync_o = hold > 0;
endmodule : nms_far_master
`default_nettype wire

// >>> test/test_nms_group_sync.sv
/*
 * Self-checking bench for the NCO group sync block.
 * Assumes the checker is bound and the far master model is present.
 */
`timescale 1ns/10ps
`default_nettype none
module test_nms_group_sync;
    import nms_pkg::*;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } nms_row_t;
    nms_row_t rows [10] = '{'{0, 12'h0CC, 8'h00, 8'h04},
        '{0, 12'h0CB, 8'h00, 8'h15}, '{0, 12'h0C7, 8'h00, 8'h80},
        '{0, 12'h0C8, 8'h00, 8'h01}, '{0, 12'h0D0, 8'h00, 8'h00},
        '{1, 12'h0C8, 8'hFF, 8'h17}, '{1, 12'h0CB, 8'hEE, 8'h1E},
        '{1, 12'h0D0, 8'hAA, 8'h00}, '{1, 12'h0CC, 8'hF6, 8'hF6},
        '{1, 12'h0C8, 8'h01, 8'h01}};
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [11:0] reg_addr_i = 12'h000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic sysref_i = 1'b0;
    logic [10:0] link_multiframe_period_i = 11'h00C;
    logic send = 1'b0;
    logic [7:0] reg_rdata_o;
    logic group_sync_in_i;
    logic group_sync_out_o;
    logic multiframe_clk_o;
    logic nco_reset_o;
    int fail_count = 0;
    int check_count = 0;
    always #2 clk_i = ~clk_i;
    nms_group_sync dut_u (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i,
        .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .sysref_i,
        .link_multiframe_period_i, .group_sync_in_i, .group_sync_out_o,
        .multiframe_clk_o, .nco_reset_o);
    nms_far_master far_u (.clk_i, .send_i(send), .sync_o(group_sync_in_i));
    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic cmp(input string n, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask : cmp
    // Register cycles start and end on a falling edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        d = reg_rdata_o;
        @(negedge clk_i);
    endtask : rd
    task automatic mf_edge(input logic l, output int n);
        logic p;
        p = multiframe_clk_o;
        for (n = 1; n < 200; n++) begin
            @(negedge clk_i);
            if (multiframe_clk_o === l && p !== l) return;
            p = multiframe_clk_o;
        end
        cmp("timeout", 0, 1);
        wrap_up();
    endtask : mf_edge
    task automatic quiet(input int b, output logic s);
        s = 1'b0;
        for (int i = 0; i < b && !s; i++) begin
            @(negedge clk_i);
            s = nco_reset_o === 1'b1;
        end
    endtask : quiet
    task automatic run_sync(input logic [7:0] c, input logic [7:0] s,
        input logic l, input int k, input logic o);
        int n;
        int e;
        logic p;
        wr(12'h0CC, c);
        wr(12'h0CB, s);
        mf_edge(1'b1, n);
        sysref_i = 1'b1;
        repeat (2) @(negedge clk_i);
        sysref_i = 1'b0;
        e = 0;
        p = multiframe_clk_o;
        for (n = 0; n < 200 && nco_reset_o !== 1'b1; n++) begin
            @(negedge clk_i);
            if (multiframe_clk_o === l && p !== l) e++;
            p = multiframe_clk_o;
        end
        cmp("fired", 1, nco_reset_o);
        if (nco_reset_o !== 1'b1) wrap_up();
        cmp("edges", k, e);
        cmp("out", o, group_sync_out_o);
    endtask : run_sync
    initial begin
        logic [7:0] v;
        logic s;
        int n;
        logic [2:0] q;
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            cmp("register", rows[i].e, v);
        end
        mf_edge(1'b1, n);
        mf_edge(1'b1, n);
        cmp("link period", 12, n);
        wr(12'h0C7, 8'h10);
        wr(12'h0C8, 8'h10);
        mf_edge(1'b1, n);
        mf_edge(1'b1, n);
        cmp("sw period", 16, n);
        run_sync(8'h25, 8'h01, 1'b1, 3, 1'b1);
        run_sync(8'h19, 8'h01, 1'b0, 2, 1'b1);
        run_sync(8'h51, 8'h01, 1'b1, 0, 1'b1);
        run_sync(8'h34, 8'h01, 1'b1, 1, 1'b0);
        run_sync(8'h07, 8'h02, 1'b0, 1, 1'b0);
        run_sync(8'h04, 8'h00, 1'b1, 0, 1'b0);
        wr(12'h0CC, 8'h06);
        sysref_i = 1'b1;
        repeat (3) @(negedge clk_i);
        sysref_i = 1'b0;
        quiet(40, s);
        cmp("slave sysref", 0, s);
        send = 1'b1;
        @(negedge clk_i);
        send = 1'b0;
        quiet(60, s);
        cmp("slave sync", 1, s);
        cmp("slave out", 0, group_sync_out_o);
        sys_rst_i = 1'b1;
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        q = {nco_reset_o, group_sync_out_o, multiframe_clk_o};
        cmp("reset outs", 0, q);
        rd(12'h0CC, v);
        cmp("reset control", 8'h04, v);
        rd(12'h0C8, v);
        cmp("reset period", 8'h01, v);
        wrap_up();
    end
endmodule : test_nms_group_sync
`default_nettype wire
